// ### design/enpd_map.vh
// constants for the ethernet network-column packet distributor
`ifndef ENPD_MAP_VH
`define ENPD_MAP_VH
`define ENPD_MODE_DIRECT  2'h0
`define ENPD_MODE_PACKET  2'h1
`define ENPD_MODE_QUAD    2'h2
`define ENPD_WORD_W       256
`define ENPD_BUS_W        1024
`define ENPD_NUM_AP       4
`define ENPD_SEQ_W        16
`define ENPD_COL_W        3
`define ENPD_COL_WEST_0   3'h1
`define ENPD_COL_WEST_1   3'h2
`define ENPD_COL_EAST_0   3'h4
`define ENPD_COL_EAST_1   3'h5
`define ENPD_MASK_400     4'hf
`define ENPD_MASK_200     4'h3
`define ENPD_SEQ_RST      16'h0000
`endif

// ### design/enpd_buf2.v
// two-entry buffer with registered output, valid and ready on both sides
module enpd_buf2 #(
  parameter W = 274
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg         out_valid_r;
  reg [W-1:0] out_data_r;
  reg         skid_valid_r;
  reg [W-1:0] skid_data_r;

  // ready depends only on the second entry, so it comes from a flop
  assign in_ready  = ~skid_valid_r;
  assign out_valid = out_valid_r;
  assign out_data  = out_data_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid_r  <= 1'b0;
      out_data_r   <= {W{1'b0}};
      skid_valid_r <= 1'b0;
      skid_data_r  <= {W{1'b0}};
    end else if (out_ready || !out_valid_r) begin
      if (skid_valid_r) begin
        out_data_r   <= skid_data_r;
        out_valid_r  <= 1'b1;
        skid_valid_r <= 1'b0;
      end else begin
        out_valid_r <= in_valid;
        out_data_r  <= in_data;
      end
    end else if (in_valid && !skid_valid_r) begin
      // receiver stalled: park the word instead of dropping it
      skid_data_r  <= in_data;
      skid_valid_r <= 1'b1;
    end
  end
endmodule

// ### design/enpd_distributor.v
// ethernet receive traffic distributor onto four column access points
`include "enpd_map.vh"
module enpd_distributor #(
  parameter SEQ_W = `ENPD_SEQ_W
) (
  input  wire                            clk,
  input  wire                            rst,
  input  wire [1:0]                      cfg_mode,
  input  wire                            cfg_rate_400,
  input  wire                            cfg_subsys_east,
  input  wire                            in_valid,
  output wire                            in_ready,
  input  wire [`ENPD_BUS_W-1:0]          in_data,
  input  wire                            in_sop,
  input  wire                            in_eop,
  input  wire [1:0]                      in_last_word,
  input  wire [`ENPD_NUM_AP-1:0]         in_seg_valid,
  input  wire [`ENPD_NUM_AP-1:0]         in_seg_sop,
  input  wire [`ENPD_NUM_AP-1:0]         in_seg_eop,
  output wire [`ENPD_NUM_AP-1:0]         ap_valid,
  input  wire [`ENPD_NUM_AP-1:0]         ap_ready,
  output wire [`ENPD_BUS_W-1:0]          ap_data,
  output wire [`ENPD_NUM_AP-1:0]         ap_sop,
  output wire [`ENPD_NUM_AP-1:0]         ap_eop,
  output wire [`ENPD_NUM_AP*SEQ_W-1:0]   ap_seq,
  output wire [`ENPD_NUM_AP*`ENPD_COL_W-1:0] ap_column
);
  localparam WW = `ENPD_WORD_W;
  localparam BW = WW + SEQ_W + 2;

  // round-robin search for the next free access point
  function [2:0] pick_free;
    input [3:0] mask;
    input [1:0] start;
    integer     i;
    reg   [1:0] idx;
    begin
      pick_free = 3'h0;
      for (i = 3; i >= 0; i = i - 1) begin
        idx = start + i[1:0];
        if (mask[idx])
          pick_free = {1'b1, idx};
      end
    end
  endfunction

  reg [1:0]                  mode_r;
  reg                        rate_400_r;
  reg [`ENPD_NUM_AP*`ENPD_COL_W-1:0] column_r;
  reg                        in_ready_r;
  reg                        hold_valid_r;
  reg [`ENPD_BUS_W-1:0]      hold_data_r;
  reg                        hold_sop_r;
  reg                        hold_eop_r;
  reg [1:0]                  hold_last_r;
  reg [3:0]                  hold_segv_r;
  reg [3:0]                  hold_ssop_r;
  reg [3:0]                  hold_seop_r;
  reg [1:0]                  word_idx_r;
  reg [1:0]                  word_idx_nxt;
  reg [1:0]                  path_r;
  reg [1:0]                  path_nxt;
  reg                        in_pkt_r;
  reg                        in_pkt_nxt;
  reg [1:0]                  rr_r;
  reg [1:0]                  rr_nxt;
  reg [SEQ_W-1:0]            seq_r;
  reg [SEQ_W-1:0]            seq_nxt;
  reg [SEQ_W-1:0]            pkt_seq_r;
  reg [SEQ_W-1:0]            pkt_seq_nxt;
  reg [SEQ_W-1:0]            push_seq;
  reg [3:0]                  push;
  reg [3:0]                  push_sop;
  reg [3:0]                  push_eop;
  reg                        hold_clr;
  reg                        first;
  reg                        ok;
  reg [1:0]                  sel;
  reg [2:0]                  found;
  wire [3:0]                 buf_rdy;
  wire [3:0]                 act_mask;
  wire [WW-1:0]              word_data;
  wire                       take;
  wire                       hold_valid_nxt;

  assign act_mask  = rate_400_r ? `ENPD_MASK_400 : `ENPD_MASK_200;
  assign word_data = hold_data_r[{word_idx_r, 8'h00} +: WW];
  assign take      = in_ready_r & in_valid;
  assign in_ready  = in_ready_r;
  assign ap_column = column_r;
  assign hold_valid_nxt = (hold_valid_r & ~hold_clr) | take;

  always @* begin
    push         = 4'h0;
    push_sop     = 4'h0;
    push_eop     = 4'h0;
    push_seq     = {SEQ_W{1'b0}};
    hold_clr     = 1'b0;
    word_idx_nxt = word_idx_r;
    path_nxt     = path_r;
    in_pkt_nxt   = in_pkt_r;
    rr_nxt       = rr_r;
    seq_nxt      = seq_r;
    pkt_seq_nxt  = pkt_seq_r;
    first        = hold_sop_r && (word_idx_r == 2'h0);
    found        = pick_free(buf_rdy & act_mask, rr_r);
    sel          = (in_pkt_r && !first) ? path_r : found[1:0];
    ok           = (in_pkt_r && !first) ? buf_rdy[path_r] : found[2];
    if (hold_valid_r) begin
      case (mode_r)
        `ENPD_MODE_DIRECT: begin
          if (buf_rdy[0]) begin
            push[0]     = 1'b1;
            push_sop[0] = hold_sop_r;
            push_eop[0] = hold_eop_r;
            hold_clr    = 1'b1;
          end
        end
        `ENPD_MODE_PACKET: begin
          if (!first && !in_pkt_r) begin
            // a beat with no packet open is discarded rather than misrouted
            hold_clr = 1'b1;
          end else if (ok) begin
            push[sel] = 1'b1;
            push_seq  = first ? seq_r : pkt_seq_r;
            if (first) begin
              push_sop[sel] = 1'b1;
              pkt_seq_nxt   = seq_r;
              seq_nxt       = seq_r + 1'b1;
              path_nxt      = sel;
              in_pkt_nxt    = 1'b1;
              rr_nxt        = (sel + 2'h1) & (rate_400_r ? 2'h3 : 2'h1);
            end
            if (word_idx_r == hold_last_r) begin
              hold_clr     = 1'b1;
              word_idx_nxt = 2'h0;
              if (hold_eop_r) begin
                push_eop[sel] = 1'b1;
                in_pkt_nxt    = 1'b0;
              end
            end else begin
              word_idx_nxt = word_idx_r + 2'h1;
            end
          end
        end
        `ENPD_MODE_QUAD: begin
          // the beat waits until all four points are ready, so the beat order holds
          if (&buf_rdy) begin
            push     = hold_segv_r;
            push_sop = hold_ssop_r;
            push_eop = hold_seop_r;
            hold_clr = 1'b1;
          end
        end
        default: hold_clr = 1'b1;
      endcase
    end
  end

  genvar k;
  generate
    for (k = 0; k < `ENPD_NUM_AP; k = k + 1) begin : g_ap
      wire [WW-1:0] seg_data;
      wire [BW-1:0] bin;
      wire [BW-1:0] bout;
      assign seg_data = (mode_r == `ENPD_MODE_QUAD) ?
                        hold_data_r[k*WW +: WW] : word_data;
      assign bin = {push_seq, push_sop[k], push_eop[k], seg_data};
      // the buffer decouples each point's stall from the rest of the path
      enpd_buf2 #(
        .W (BW)
      ) u_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push[k]),
        .in_ready  (buf_rdy[k]),
        .in_data   (bin),
        .out_valid (ap_valid[k]),
        .out_ready (ap_ready[k]),
        .out_data  (bout)
      );
      assign ap_data[k*WW +: WW]       = bout[WW-1:0];
      assign ap_eop[k]                 = bout[WW];
      assign ap_sop[k]                 = bout[WW+1];
      assign ap_seq[k*SEQ_W +: SEQ_W]  = bout[BW-1 -: SEQ_W];
    end
  endgenerate

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r       <= `ENPD_MODE_DIRECT;
      rate_400_r   <= 1'b0;
      column_r     <= {`ENPD_COL_WEST_1, `ENPD_COL_WEST_0,
                       `ENPD_COL_WEST_1, `ENPD_COL_WEST_0};
      in_ready_r   <= 1'b0;
      hold_valid_r <= 1'b0;
      hold_data_r  <= {`ENPD_BUS_W{1'b0}};
      hold_sop_r   <= 1'b0;
      hold_eop_r   <= 1'b0;
      hold_last_r  <= 2'h0;
      hold_segv_r  <= 4'h0;
      hold_ssop_r  <= 4'h0;
      hold_seop_r  <= 4'h0;
      word_idx_r   <= 2'h0;
      path_r       <= 2'h0;
      in_pkt_r     <= 1'b0;
      rr_r         <= 2'h0;
      seq_r        <= `ENPD_SEQ_RST;
      pkt_seq_r    <= `ENPD_SEQ_RST;
    end else begin
      // configuration is static; change it only while no traffic flows
      mode_r     <= cfg_mode;
      rate_400_r <= cfg_rate_400;
      // points 0,2 sit on the first own column, 1,3 on the second
      column_r   <= cfg_subsys_east ?
                    {`ENPD_COL_EAST_1, `ENPD_COL_EAST_0, `ENPD_COL_EAST_1, `ENPD_COL_EAST_0} :
                    {`ENPD_COL_WEST_1, `ENPD_COL_WEST_0,
                     `ENPD_COL_WEST_1, `ENPD_COL_WEST_0};
      in_ready_r   <= ~hold_valid_nxt;
      hold_valid_r <= hold_valid_nxt;
      if (take) begin
        hold_data_r <= in_data;
        hold_sop_r  <= in_sop;
        hold_eop_r  <= in_eop;
        hold_last_r <= (cfg_mode == `ENPD_MODE_PACKET) ? in_last_word : 2'h0;
        hold_segv_r <= in_seg_valid;
        hold_ssop_r <= in_seg_sop;
        hold_seop_r <= in_seg_eop;
      end
      word_idx_r <= word_idx_nxt;
      path_r     <= path_nxt;
      in_pkt_r   <= in_pkt_nxt;
      rr_r       <= rr_nxt;
      seq_r      <= seq_nxt;
      pkt_seq_r  <= pkt_seq_nxt;
    end
  end
endmodule

// ### testbench/enpd_ap_sink.sv
// far-side model: four access-point readers logging every word taken
module enpd_ap_sink (
  input  wire logic          clk,
  input  wire logic          hold,
  input  wire logic          slow,
  input  wire logic [3:0]    ap_valid,
  output logic      [3:0]    ap_ready,
  input  wire logic [1023:0] ap_data,
  input  wire logic [3:0]    ap_sop,
  input  wire logic [3:0]    ap_eop,
  input  wire logic [63:0]   ap_seq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [275:0] got [$];
  logic [3:0]   cnt_r = 4'h0;
  always @(negedge clk) cnt_r <= cnt_r + 4'h1;
  // slow stalls each point on its own pattern; hold stops every reader
  assign ap_ready = hold ? 4'h0 : (slow ? cnt_r ^ 4'h5 : 4'hf);
  // points are read apart, so two packets in one beat are both taken
  always @(posedge clk) begin
    for (int k = 0; k < 4; k++)
      if (ap_valid[k] && ap_ready[k])
        got.push_back({2'(k), ap_sop[k], ap_eop[k], ap_seq[16*k +: 16],
                       ap_data[256*k +: 256]});
  end
endmodule

// ### testbench/enpd_chk_props.sv
// concurrent checks on the distributor ports
module enpd_chk (
  input wire logic          clk,
  input wire logic          rst,
  input wire logic [1:0]    cfg_mode,
  input wire logic          cfg_rate_400,
  input wire logic          cfg_subsys_east,
  input wire logic          in_valid,
  input wire logic          in_ready,
  input wire logic [1023:0] in_data,
  input wire logic [3:0]    ap_valid,
  input wire logic [3:0]    ap_ready,
  input wire logic [1023:0] ap_data,
  input wire logic [11:0]   ap_column
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_col_west: assert property (!cfg_subsys_east [*2] |-> ap_column == 12'h451)
    else $error("west columns wrong");
  a_col_east: assert property (cfg_subsys_east [*2] |-> ap_column == 12'hb2c)
    else $error("east columns wrong");
  a_direct_ap0: assert property ((cfg_mode == 2'h0) [*3] |-> ap_valid[3:1] == 3'h0)
    else $error("direct word off point 0");
  a_pkt_two: assert property ((cfg_mode == 2'h1 && !cfg_rate_400) [*3] |-> !ap_valid[3:2])
    else $error("upper point used at 200G");
  a_ready_drop: assert property (in_valid && in_ready |=> !in_ready)
    else $error("ready stayed high after take");
  a_ap_hold: assert property (ap_valid[0] && !ap_ready[0] |=> ap_valid[0])
    else $error("word dropped while stalled");
  a_direct_lat: assert property (cfg_mode == 2'h0 && in_valid && in_ready && !ap_valid[0]
    |-> ##2 ap_valid[0] && in_ready) else $error("direct word late");
  a_quad_map: assert property (cfg_mode == 2'h2 && in_valid && in_ready && !ap_valid
    |-> ##2 ap_data == $past(in_data, 2)) else $error("segment misplaced");
  c_quad: cover property (cfg_mode == 2'h2 && in_valid && in_ready);
  c_pkt: cover property (cfg_mode == 2'h1 && in_valid && in_ready);
  c_stall: cover property (ap_valid[0] && !ap_ready[0] && !in_ready);
endmodule
bind enpd_distributor enpd_chk u_enpd_chk (.*);

// ### testbench/tb_top.sv
// self-checking bench for the packet distributor
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk = '0, rst = '1, hold = '0, slow = '0, in_valid = '0, in_ready;
  logic          in_sop = '1, in_eop = '1, cfg_rate_400 = '0, cfg_subsys_east = '0;
  logic [1:0]    cfg_mode = '0, in_last_word = '0;
  logic [3:0]    in_seg_valid = '0, in_seg_sop = '0, in_seg_eop = '0;
  logic [3:0]    ap_valid, ap_ready, ap_sop, ap_eop;
  logic [1023:0] in_data = '0, ap_data;
  logic [63:0]   ap_seq;
  logic [11:0]   ap_column;
  logic [275:0]  e;
  int            errors = 0, comparisons = 0;
  always #2 clk = ~clk;
  enpd_distributor u_enpd_distributor (.*);
  enpd_ap_sink u_enpd_ap_sink (.*);
  task automatic chk(input string n, input logic [275:0] s, input logic [275:0] x);
    comparisons++;
    if (s !== x) errors++;
    if (s !== x) $display("[ERR] %s expected %h seen %h", n, x, s);
  endtask
  task automatic rst_cfg(input logic [1:0] m, input logic r4, input logic ea, input logic sl);
    {rst, cfg_mode, cfg_rate_400, cfg_subsys_east, slow} = {1'h1, m, r4, ea, sl};
    repeat (6) @(negedge clk);
    rst = 1'h0;
    u_enpd_ap_sink.got.delete();
    @(negedge clk);
    chk("column", 276'(ap_column), ea ? 276'hb2c : 276'h451);
  endtask
  // f holds last word, segment valid, segment start and segment end
  task automatic send(input logic [1023:0] d, input logic [13:0] f, output bit tk);
    repeat (40) if (in_ready !== 1'h1) @(negedge clk);
    tk = (in_ready === 1'h1);
    if (tk) {in_valid, in_data, in_last_word, in_seg_valid, in_seg_sop, in_seg_eop} = {1'h1, d, f};
    @(negedge clk);
    in_valid = 1'h0;
  endtask
  task automatic wait_n(input int n);
    repeat (200) if (u_enpd_ap_sink.got.size() < n) @(negedge clk);
    chk("count", 276'(u_enpd_ap_sink.got.size()), 276'(n));
  endtask
  task automatic t_direct();
    bit tk;
    rst_cfg(2'h0, 1'h0, 1'h0, 1'h0);
    for (int i = 0; i < 6; i++) begin
      hold = (i > 0 && i < 5);
      send(1024'(i < 5 ? i : 4), 14'h0, tk);
      chk("taken", 276'(tk), 276'(i != 4));
      if (i == 0) wait_n(1);
    end
    wait_n(5);
    for (int i = 0; i < 5; i++) chk("direct", u_enpd_ap_sink.got[i], {4'h3, 272'(i)});
  endtask
  task automatic t_packet();
    bit tk;
    logic [1:0] a0;
    int j;
    rst_cfg(2'h1, 1'h1, 1'h1, 1'h0);
    for (int i = 0; i < 5; i++) send(1024'(i), 14'h0, tk);
    send({256'h8, 256'h7, 256'h6, 256'h5}, 14'h3000, tk);
    wait_n(9);
    // round robin starts at point 0 after reset
    a0 = 2'h0;
    for (int i = 0; i < 9; i++) begin
      j = i < 5 ? i : 5;
      e = u_enpd_ap_sink.got[i];
      chk("packet", e, {a0 + 2'(j), i <= 5, i < 5 || i == 8, 16'(j), 256'(i)});
    end
  endtask
  task automatic t_pkt200();
    bit tk;
    rst_cfg(2'h1, 1'h0, 1'h0, 1'h0);
    for (int i = 0; i < 3; i++) send(1024'(i), 14'h0, tk);
    wait_n(3);
    for (int i = 0; i < 3; i++)
      chk("pkt200", u_enpd_ap_sink.got[i], {2'(i % 2), 2'h3, 16'(i), 256'(i)});
    // undefined mode: the beat is taken but nothing reaches any point
    rst_cfg(2'h3, 1'h0, 1'h0, 1'h0);
    send(1024'h1, 14'h0, tk);
    repeat (6) @(negedge clk);
    chk("discard", 276'(u_enpd_ap_sink.got.size()), 276'(0));
  endtask
  task automatic t_quad();
    bit tk;
    int nb[4] = '{0, 0, 0, 0};
    logic [1:0] k;
    rst_cfg(2'h2, 1'h0, 1'h0, 1'h1);
    send({256'h3, 256'h2, 256'h1, 256'h0}, 14'h0f52, tk);
    send({256'h13, 256'h12, 256'h11, 256'h10}, 14'h0f08, tk);
    wait_n(8);
    for (int i = 0; i < 8; i++) begin
      e = u_enpd_ap_sink.got[i];
      k = e[275:274];
      chk("quad", e, {k, nb[k] ? {1'h0, k == 3} : {!k[0], k == 1}, 16'h0,
                      256'(16 * nb[k] + k)});
      nb[k]++;
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #40000;
    errors++;
    give_verdict();
  end
  initial begin
    t_direct();
    t_packet();
    t_pkt200();
    t_quad();
    give_verdict();
  end
endmodule
